// *** inc/ofs_params.svh ***
// constants of the oscillator frequency, trim and subsystem clock select block
`ifndef OFS_PARAMS_SVH
`define OFS_PARAMS_SVH

// ***************************************************************
// register byte addresses
// ***************************************************************
`define OFS_ADDR_SUBSEL 32'h4002_0407
`define OFS_ADDR_TIMER_SEL 32'h4002_0423
`define OFS_ADDR_TRIM 32'h4002_1c00
`define OFS_ADDR_DIV 32'h4002_1c20
`define OFS_ADDR_STATUS 32'h4002_1c24

// ***************************************************************
// field positions
// ***************************************************************
`define OFS_SUB_SRC_BIT 0
`define OFS_SLOW_FREQ_BIT 1
`define OFS_TIMER_SRC_BIT 4
`define OFS_STAT_BUSY_BIT 0

// ***************************************************************
// reset values, code limits and base frequency
// ***************************************************************
`define OFS_SUBSEL_RESET 8'h02
`define OFS_TIMER_SEL_RESET 8'h00
`define OFS_DIV_CODE_MAX 3'h5
`define OFS_BASE_FREQ_MHZ 32

// ***************************************************************
// frequency switch latencies, in clocks of the fast clock
// ***************************************************************
`define OFS_OLD_FREQ_MAX_CLKS 3
`define OFS_NEW_FREQ_WAIT_CLKS 3

`endif

// *** inc/ofs_pkg.sv ***
// types of the oscillator frequency, trim and subsystem clock select block
package ofs_pkg;

  typedef logic [2:0] ofs_div_code_t;
  typedef logic [5:0] ofs_trim_t;

  typedef enum logic [1:0] {
    SW_IDLE,
    SW_PEND,
    SW_SETTLE
  } ofs_sw_e;

endpackage

// *** hdl/ofs_div_gen.sv ***
// glitch-free divider that makes the fast internal clock from base ticks
`timescale 1ns/1ps
`include "ofs_params.svh"

module ofs_div_gen #(
  parameter int CNT_W = 6
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic base_tick_in,
  input wire logic [2:0] code_in,
  output logic clk_out,
  output logic busy_out,
  output logic [2:0] active_code_out
);

  localparam int OLD_MAX = `OFS_OLD_FREQ_MAX_CLKS;
  localparam int NEW_WAIT = `OFS_NEW_FREQ_WAIT_CLKS;

  ofs_pkg::ofs_sw_e state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] mask;
  logic [2:0] target;
  logic [1:0] edge_cnt;
  logic [2:0] old_edges;
  logic fall_point;
  logic rise_point;
  logic do_switch;

  // ***************************************************************
  // divider
  // ***************************************************************
  // one tick is half a base period, so code n gives 2^n ticks per phase
  assign mask = CNT_W'((2 << active_code_out) - 1);
  assign next_cnt = cnt + 1'b1;
  assign fall_point = base_tick_in && ((cnt & mask) == mask);
  assign rise_point = base_tick_in && !clk_out && next_cnt[active_code_out];
  assign do_switch = (state == ofs_pkg::SW_PEND) && fall_point;
  assign busy_out = (state != ofs_pkg::SW_IDLE);

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      cnt <= '0;
      clk_out <= 1'b0;
    end else if (do_switch) begin
      // switch only where the old clock falls: no short pulse
      cnt <= '0;
      clk_out <= 1'b0;
    end else if (base_tick_in) begin
      cnt <= next_cnt;
      clk_out <= next_cnt[active_code_out];
    end
  end

  // ***************************************************************
  // switch sequence
  // ***************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= ofs_pkg::SW_IDLE;
      active_code_out <= code_in;
      target <= code_in;
      edge_cnt <= 2'h0;
    end else begin
      case (state)
        ofs_pkg::SW_IDLE: begin
          if (code_in != active_code_out) begin
            target <= code_in;
            state <= ofs_pkg::SW_PEND;
          end
        end
        ofs_pkg::SW_PEND: begin
          // at most the rest of one old period elapses here
          if (fall_point) begin
            active_code_out <= target;
            edge_cnt <= 2'h0;
            state <= ofs_pkg::SW_SETTLE;
          end
        end
        ofs_pkg::SW_SETTLE: begin
          // settle for three new-frequency clocks
          if (rise_point) begin
            if (edge_cnt == 2'(NEW_WAIT - 1)) begin
              state <= ofs_pkg::SW_IDLE;
            end else begin
              edge_cnt <= edge_cnt + 2'h1;
            end
          end
        end
        default: begin
          state <= ofs_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in || state != ofs_pkg::SW_PEND) begin
      old_edges <= 3'h0;
    end else if (rise_point && old_edges != 3'h7) begin
      old_edges <= old_edges + 3'h1;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  AST_OLD_FREQ_LIMIT:
    assert property (old_edges <= 3'(OLD_MAX))
    else $error("old frequency ran too long before switch");
  AST_NEW_WAIT_DONE:
    assert property (state == ofs_pkg::SW_SETTLE && rise_point &&
                     edge_cnt == 2'(NEW_WAIT - 1) |=> !busy_out)
    else $error("switch not complete after new-frequency wait");
  AST_SWITCH_LOW:
    assert property (do_switch |=> !clk_out && cnt == '0 &&
                     active_code_out == $past(target))
    else $error("switch did not restart clock low");
  AST_EDGE_ON_TICK:
    assert property ($changed(clk_out) |-> $past(base_tick_in))
    else $error("fast clock changed without a base tick");
  COV_SWITCH_DONE:
    cover property (state == ofs_pkg::SW_SETTLE ##1 state == ofs_pkg::SW_IDLE);

endmodule

// *** hdl/ofs_top.sv ***
// register block for fast oscillator divider and trim and slow clock select
`timescale 1ns/1ps
`include "ofs_params.svh"

module ofs_top #(
  parameter int ADDR_W = 32,
  parameter int CNT_W = 6
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [2:0] option_freq_code_in,
  input wire logic [5:0] factory_trim_in,
  input wire logic fast_osc_base_clock_in,
  input wire logic external_sub_clock_in,
  input wire logic slow_internal_clock_in,
  output logic [2:0] fast_osc_divider_code_out,
  output logic [5:0] fast_osc_trim_code_out,
  output logic fast_internal_clock_out,
  output logic fast_switch_busy_out,
  output logic slow_osc_freq_select_out,
  output logic sub_clock_source_select_out,
  output logic subsystem_clock_out,
  output logic slow_clock_source_for_timers_out,
  output logic slow_osc_force_run_out,
  output logic timer_clock_out
);

  // ***************************************************************
  // decode
  // ***************************************************************
  localparam logic [ADDR_W-1:0] A_SUBSEL = ADDR_W'(`OFS_ADDR_SUBSEL);
  localparam logic [ADDR_W-1:0] A_TSEL = ADDR_W'(`OFS_ADDR_TIMER_SEL);
  localparam logic [ADDR_W-1:0] A_TRIM = ADDR_W'(`OFS_ADDR_TRIM);
  localparam logic [ADDR_W-1:0] A_DIV = ADDR_W'(`OFS_ADDR_DIV);
  localparam logic [ADDR_W-1:0] A_STAT = ADDR_W'(`OFS_ADDR_STATUS);

  ofs_pkg::ofs_div_code_t div_code;
  ofs_pkg::ofs_trim_t trim_code;
  logic slow_freq_sel;
  logic sub_src_sel;
  logic timer_src_sel;
  logic [2:0] active_code;
  logic switch_busy;
  logic fast_clk;
  logic wr_div;
  logic wr_trim;
  logic wr_subsel;
  logic wr_tsel;
  logic div_code_legal;
  logic [7:0] next_rdata;

  // 8-bit transfers only; byte lanes do not exist on this port
  assign wr_div = wr_in && (addr_in == A_DIV);
  assign wr_trim = wr_in && (addr_in == A_TRIM);
  assign wr_subsel = wr_in && (addr_in == A_SUBSEL);
  assign wr_tsel = wr_in && (addr_in == A_TSEL);
  assign div_code_legal = (wdata_in[2:0] <= `OFS_DIV_CODE_MAX);

  // ***************************************************************
  // divider code register
  // ***************************************************************
  // the strap is taken by the synchronous reset itself
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      div_code <= option_freq_code_in;
    end else if (wr_div && div_code_legal) begin
      // prohibited codes 6 and 7 leave the old code in place
      div_code <= wdata_in[2:0];
    end
  end

  // ***************************************************************
  // trim register
  // ***************************************************************
  // factory value arrives on a port; it is not a fixed constant
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      trim_code <= factory_trim_in;
    end else if (wr_trim) begin
      // code is monotonic: higher runs faster
      trim_code <= wdata_in[5:0];
    end
  end

  // ***************************************************************
  // subsystem clock select register
  // ***************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      // 32.768 kHz slow oscillator, external subsystem clock
      slow_freq_sel <= 1'(`OFS_SUBSEL_RESET >> `OFS_SLOW_FREQ_BIT);
      sub_src_sel <= 1'(`OFS_SUBSEL_RESET >> `OFS_SUB_SRC_BIT);
    end else if (wr_subsel) begin
      slow_freq_sel <= wdata_in[`OFS_SLOW_FREQ_BIT];
      sub_src_sel <= wdata_in[`OFS_SUB_SRC_BIT];
    end
  end

  // ***************************************************************
  // timer clock source register
  // ***************************************************************
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      timer_src_sel <= 1'(`OFS_TIMER_SEL_RESET >> `OFS_TIMER_SRC_BIT);
    end else if (wr_tsel) begin
      timer_src_sel <= wdata_in[`OFS_TIMER_SRC_BIT];
    end
  end

  // ***************************************************************
  // read port
  // ***************************************************************
  always_comb begin
    next_rdata = 8'h00;
    case (addr_in)
      // unassigned bits stay zero in every word below
      A_DIV: begin
        next_rdata = {5'h00, div_code};
      end
      A_TRIM: begin
        next_rdata = {2'h0, trim_code};
      end
      A_SUBSEL: begin
        next_rdata[`OFS_SLOW_FREQ_BIT] = slow_freq_sel;
        next_rdata[`OFS_SUB_SRC_BIT] = sub_src_sel;
      end
      A_TSEL: begin
        next_rdata[`OFS_TIMER_SRC_BIT] = timer_src_sel;
      end
      A_STAT: begin
        next_rdata = {4'h0, active_code, switch_busy};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= next_rdata;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ***************************************************************
  // fast clock generation
  // ***************************************************************
  // base at 32 MHz divided by 2^code gives 32,16,8,4,2,1 MHz
  ofs_div_gen #(
    .CNT_W(CNT_W)
  ) u_div_gen (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .base_tick_in(fast_osc_base_clock_in),
    .code_in(div_code),
    .clk_out(fast_clk),
    .busy_out(switch_busy),
    .active_code_out(active_code)
  );

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign fast_osc_divider_code_out = div_code;
  // the analog trim moves the oscillator by roughly 0.05 percent a step
  assign fast_osc_trim_code_out = trim_code;
  assign fast_internal_clock_out = fast_clk;
  assign fast_switch_busy_out = switch_busy;
  assign slow_osc_freq_select_out = slow_freq_sel;
  assign sub_clock_source_select_out = sub_src_sel;
  assign slow_clock_source_for_timers_out = timer_src_sel;

  // mux outputs are registered so a select change cannot glitch them
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      subsystem_clock_out <= 1'b0;
      timer_clock_out <= 1'b0;
      slow_osc_force_run_out <= 1'b0;
    end else begin
      // external when clear, slow oscillator when set
      subsystem_clock_out <= sub_src_sel ? slow_internal_clock_in :
                             external_sub_clock_in;
      // timers then run from the slow oscillator, which must run
      timer_clock_out <= timer_src_sel ? slow_internal_clock_in :
                         (sub_src_sel ? slow_internal_clock_in :
                          external_sub_clock_in);
      slow_osc_force_run_out <= timer_src_sel;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);

  AST_DIV_STRAP_LOAD:
    assert property ($fell(reset_in) |->
                     div_code == $past(option_freq_code_in))
    else $error("divider code not loaded from option code at reset");
  AST_DIV_LEGAL_WRITE:
    assert property (wr_div && div_code_legal |=>
                     fast_osc_divider_code_out == $past(wdata_in[2:0]))
    else $error("legal divider write not stored");
  AST_DIV_BAD_WRITE:
    assert property (wr_div && !div_code_legal |=> $stable(div_code))
    else $error("prohibited divider code was stored");
  AST_TRIM_FACTORY:
    assert property ($fell(reset_in) |->
                     trim_code == $past(factory_trim_in))
    else $error("trim not loaded from factory value at reset");
  AST_TRIM_WRITE:
    assert property (wr_trim |=>
                     fast_osc_trim_code_out == $past(wdata_in[5:0]))
    else $error("trim write not stored");
  AST_SUBSEL_RESET:
    assert property ($fell(reset_in) |->
                     slow_freq_sel && !sub_src_sel)
    else $error("subsystem select not 02h after reset");
  AST_SLOW_FREQ_SEL:
    assert property (wr_subsel |=> slow_osc_freq_select_out ==
                     $past(wdata_in[`OFS_SLOW_FREQ_BIT]))
    else $error("slow oscillator frequency select wrong");
  AST_SUB_SOURCE_MUX:
    assert property (!$past(reset_in) |-> subsystem_clock_out ==
                     ($past(sub_src_sel) ? $past(slow_internal_clock_in) :
                      $past(external_sub_clock_in)))
    else $error("subsystem clock from wrong source");
  AST_TIMER_SLOW_SRC:
    assert property (timer_src_sel ##1 timer_src_sel |->
                     slow_osc_force_run_out &&
                     timer_clock_out == $past(slow_internal_clock_in))
    else $error("timer clock not from running slow oscillator");
  AST_DIV_READ_ZERO:
    assert property (rd_in && addr_in == A_DIV |=>
                     rdata_out[7:3] == 5'h00 &&
                     rdata_out[2:0] == $past(div_code))
    else $error("divider read shows bad upper bits or value");
  AST_SUBSEL_READ_ZERO:
    assert property (rd_in && addr_in == A_SUBSEL |=>
                     rdata_out[7:2] == 6'h00)
    else $error("subsystem select reads nonzero spare bits");
  AST_SWITCH_BOUNDED:
    assert property ($rose(switch_busy) |-> ##[1:1000] !switch_busy)
    else $error("frequency switch did not finish in time");
  AST_NO_RDATA_IDLE:
    assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data present without read strobe");

  COV_DIV_CHANGE:
    cover property (wr_div && div_code_legal ##1 $rose(switch_busy));
  COV_BAD_CODE:
    cover property (wr_div && !div_code_legal);
  COV_SLOW_SOURCE:
    cover property (wr_subsel && wdata_in[`OFS_SUB_SRC_BIT]);
  COV_TIMER_SLOW:
    cover property ($rose(slow_osc_force_run_out));

endmodule

// *** verification/ofs_top_bench.sv ***
// self-checking testbench of the oscillator divider, trim and clock select
`timescale 1ns/1ps
`include "ofs_params.svh"

module ofs_top_bench;
  // ***************************************************************
  // stimulus signals and counters
  // ***************************************************************
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [31:0] addr_in = 32'h0000_0000;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [2:0] strap = 3'h3;
  logic [5:0] ftrim = 6'h2a;
  logic tick = 1'b0;
  logic ext_clk = 1'b0;
  logic slow_clk = 1'b0;
  logic [3:0] ext_cnt = 4'h0;
  logic [3:0] slow_cnt = 4'h0;
  logic [7:0] rdata_out;
  logic [2:0] div_code;
  logic [5:0] trim_code;
  logic fast_clk, busy, slow_freq, src_sel, sub_clk, tmr_sel, force_run;
  logic tmr_clk;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  localparam int TIMEOUT_CYCLES = 20000;

  ofs_top dut_u (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .option_freq_code_in(strap),
    .factory_trim_in(ftrim), .fast_osc_base_clock_in(tick),
    .external_sub_clock_in(ext_clk), .slow_internal_clock_in(slow_clk),
    .fast_osc_divider_code_out(div_code),
    .fast_osc_trim_code_out(trim_code),
    .fast_internal_clock_out(fast_clk), .fast_switch_busy_out(busy),
    .slow_osc_freq_select_out(slow_freq),
    .sub_clock_source_select_out(src_sel),
    .subsystem_clock_out(sub_clk),
    .slow_clock_source_for_timers_out(tmr_sel),
    .slow_osc_force_run_out(force_run), .timer_clock_out(tmr_clk)
  );

  initial begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end

  // base ticks every other cycle; two unrelated slow clock levels
  always @(posedge sys_clk_in) begin
    tick <= ~tick;
    ext_cnt <= (ext_cnt == 4'h2) ? 4'h0 : ext_cnt + 4'h1;
    slow_cnt <= (slow_cnt == 4'h6) ? 4'h0 : slow_cnt + 4'h1;
    if (ext_cnt == 4'h2) ext_clk <= ~ext_clk;
    if (slow_cnt == 4'h6) slow_clk <= ~slow_clk;
  end

  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == TIMEOUT_CYCLES) begin
      err_count = err_count + 1;
      final_report();
    end
  end

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus_wr(input logic [31:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic bus_rd(input logic [31:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic rd_check(input string name, input logic [31:0] a,
                          input logic [7:0] exp);
    logic [7:0] d;
    bus_rd(a, d);
    check(name, d, exp);
  endtask

  task automatic do_reset();
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (5) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
  endtask

  task final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ***************************************************************
  // register table: address, write value, expected read back
  // ***************************************************************
  localparam int NROWS = 8;
  logic [31:0] row_a [NROWS] = '{`OFS_ADDR_SUBSEL, `OFS_ADDR_SUBSEL,
    `OFS_ADDR_TRIM, `OFS_ADDR_TRIM, `OFS_ADDR_DIV, `OFS_ADDR_DIV,
    32'h4002_1c10, `OFS_ADDR_TIMER_SEL};
  logic [7:0] row_w [NROWS] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'hf5,
    8'h07, 8'h5a, 8'hff};
  logic [7:0] row_e [NROWS] = '{8'h03, 8'h00, 8'h3f, 8'h00, 8'h05,
    8'h05, 8'h00, 8'h10};

  initial begin : main
    logic [7:0] d;
    int n;
    int t;
    // ***************************************************************
    // reset values
    // ***************************************************************
    do_reset();
    check("div_code", {5'h00, div_code}, 8'h03);
    check("trim_code", {2'h0, trim_code}, 8'h2a);
    rd_check("subsel", `OFS_ADDR_SUBSEL, `OFS_SUBSEL_RESET);
    rd_check("trim", `OFS_ADDR_TRIM, 8'h2a);
    rd_check("div", `OFS_ADDR_DIV, 8'h03);
    $display("test reset values done");

    // ***************************************************************
    // ordinary register rows
    // ***************************************************************
    for (int i = 0; i < NROWS; i++) begin
      bus_wr(row_a[i], row_w[i]);
      rd_check("row", row_a[i], row_e[i]);
    end
    $display("test register rows done");

    // ***************************************************************
    // every legal divider code: latency and half period
    // ***************************************************************
    for (int c = 0; c < 6; c++) begin
      // a switch still running would queue the new code behind it
      t = 0;
      while (busy !== 1'b0 && t < 1000) begin
        @(posedge sys_clk_in);
        #1;
        t++;
      end
      check("idle_before", {7'h00, busy}, 8'h00);
      bus_wr(`OFS_ADDR_DIV, 8'(c));
      t = 0;
      while (busy !== 1'b1 && t < 3) begin
        @(posedge sys_clk_in);
        #1;
        t++;
      end
      check("busy_rise", {7'h00, busy}, 8'h01);
      t = 0;
      while (busy !== 1'b0 && t < 1000) begin
        @(posedge sys_clk_in);
        #1;
        t++;
      end
      check("busy_fall", {7'h00, busy}, 8'h00);
      check("div_code", {5'h00, div_code}, 8'(c));
      rd_check("status", `OFS_ADDR_STATUS, 8'(c << 1));
      // start from a low phase so a whole high phase is measured
      t = 0;
      while (fast_clk !== 1'b0 && t < 200) begin
        @(posedge sys_clk_in);
        #1;
        t++;
      end
      t = 0;
      while (fast_clk !== 1'b1 && t < 200) begin
        @(posedge sys_clk_in);
        #1;
        t++;
      end
      n = 0;
      while (fast_clk === 1'b1 && n < 200) begin
        @(posedge sys_clk_in);
        #1;
        n++;
      end
      check("half_period", 8'(n), 8'(2 << c));
    end
    bus_wr(`OFS_ADDR_DIV, 8'h06);
    rd_check("div_prohibited", `OFS_ADDR_DIV, 8'h05);
    $display("test divider codes done");

    // ***************************************************************
    // subsystem and timer clock routing
    // ***************************************************************
    for (int s = 0; s < 2; s++) begin
      bus_wr(`OFS_ADDR_SUBSEL, 8'(s));
      bus_wr(`OFS_ADDR_TIMER_SEL, 8'h10);
      repeat (3) @(posedge sys_clk_in);
      #1;
      check("src_sel", {7'h00, src_sel}, 8'(s));
      check("slow_freq", {7'h00, slow_freq}, 8'h00);
      check("force_run", {7'h00, force_run}, 8'h01);
      check("tmr_sel", {7'h00, tmr_sel}, 8'h01);
      for (int k = 0; k < 20; k++) begin
        d = {5'h00, slow_clk, ext_clk, (s == 0) ? ext_clk : slow_clk};
        @(posedge sys_clk_in);
        #1;
        check("sub_clk", {7'h00, sub_clk}, {7'h00, d[0]});
        check("tmr_clk", {7'h00, tmr_clk}, {7'h00, d[2]});
      end
    end
    bus_wr(`OFS_ADDR_TIMER_SEL, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    #1;
    check("force_off", {7'h00, force_run}, 8'h00);
    $display("test clock routing done");

    // ***************************************************************
    // second reset with new strap and calibration
    // ***************************************************************
    @(posedge sys_clk_in);
    strap <= 3'h1;
    ftrim <= 6'h3f;
    do_reset();
    rd_check("div2", `OFS_ADDR_DIV, 8'h01);
    rd_check("trim2", `OFS_ADDR_TRIM, 8'h3f);
    rd_check("subsel2", `OFS_ADDR_SUBSEL, 8'h02);
    check("slow_freq2", {7'h00, slow_freq}, 8'h01);
    rd_check("timer2", `OFS_ADDR_TIMER_SEL, 8'h00);
    $display("test second reset done");
    final_report();
  end
endmodule
